// ---- common/tofrs_regs.svh ----
// Offsets, field positions, reset values and widths of the result register group.
`ifndef TOFRS_REGS_SVH
`define TOFRS_REGS_SVH
`define TOFRS_ADDR_W 8
`define TOFRS_DATA_W 24
`define TOFRS_PHASE_ADDR 8'h08
`define TOFRS_AMP_ADDR 8'h09
`define TOFRS_TEMP_ADDR 8'h0A
`define TOFRS_CTL_ADDR 8'h0B
`define TOFRS_PHASE_RST 24'h000000
`define TOFRS_AMP_RST 24'h000000
`define TOFRS_TEMP_RST 24'h000000
`define TOFRS_CTL_RST 24'h0FC009
`define TOFRS_CTR_RST 5'h00
`define TOFRS_PH_CTR0_POS 23
`define TOFRS_PH_AMBSAT_POS 22
`define TOFRS_PH_MOD_POS 21
`define TOFRS_PH_VALID_POS 20
`define TOFRS_PH_EMIT_HI 19
`define TOFRS_PH_EMIT_LO 18
`define TOFRS_PH_DRIVE_POS 17
`define TOFRS_PH_WRAP_POS 16
`define TOFRS_AMP_SIGSAT_POS 18
`define TOFRS_CTL_CAL_HI 23
`define TOFRS_CTL_CAL_LO 14
`define TOFRS_CTL_SEL2_HI 13
`define TOFRS_CTL_SEL2_LO 10
`define TOFRS_CTL_ZERO_HI 9
`define TOFRS_CTL_ZERO_LO 8
`define TOFRS_CTL_SEL1_HI 7
`define TOFRS_CTL_SEL1_LO 4
`define TOFRS_CTL_SEL0_HI 3
`define TOFRS_CTL_SEL0_LO 0
`endif

// ---- common/tofrs_pkg.sv ----
// Types shared by the result register group.
package tofrs_pkg;
  typedef enum logic [3:0] {
    TOFRS_SEL_FRAME_SYNC = 4'h0,
    TOFRS_SEL_SUBFRAME_SYNC = 4'h1,
    TOFRS_SEL_SEQ_IRQ = 4'h4,
    TOFRS_SEL_COMP_STATUS = 4'h8,
    TOFRS_SEL_DATA_READY = 4'h9,
    TOFRS_SEL_CTR_LSB = 4'hA
  } tofrs_sel_t;
endpackage : tofrs_pkg

// ---- hdl/tofrs_top.sv ----
// Per-frame result registers, calibration/output-select register and output routing.
`timescale 1ns/1ns
`include "tofrs_regs.svh"

module tofrs_top
  import tofrs_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic [`TOFRS_ADDR_W-1:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [`TOFRS_DATA_W-1:0] i_reg_wdata,
  output logic [`TOFRS_DATA_W-1:0] o_reg_rdata,
  input wire logic i_frame_done,
  input wire logic [15:0] i_phase,
  input wire logic i_phase_wrap,
  input wire logic i_modulation_choice,
  input wire logic i_internal_crosstalk_cal,
  input wire logic i_optical_crosstalk_cal,
  input wire logic [1:0] i_emitter,
  input wire logic i_drive_level_used,
  input wire logic [3:0] i_range_bin,
  input wire logic i_second_freq_wrap,
  input wire logic i_signal_saturated,
  input wire logic [15:0] i_echo_amplitude,
  input wire logic [11:0] i_die_temperature,
  input wire logic [9:0] i_ambient_level,
  input wire logic [9:0] i_ambient_limit,
  input wire logic i_frame_sync,
  input wire logic i_subframe_sync,
  input wire logic i_seq_interrupt,
  input wire logic i_comp_status,
  output logic o_general_output_a,
  output logic o_general_output_b,
  output logic o_general_output_c
);

  logic [`TOFRS_DATA_W-1:0] phase_result;
  logic [`TOFRS_DATA_W-1:0] amplitude_result;
  logic [`TOFRS_DATA_W-1:0] temperature_ambient_result;
  logic [`TOFRS_DATA_W-1:0] ambient_cal_and_output_select;
  logic [4:0] frame_ctr;
  logic data_ready;
  logic [`TOFRS_DATA_W-1:0] next_phase_result;
  logic [`TOFRS_DATA_W-1:0] next_amplitude_result;
  logic [`TOFRS_DATA_W-1:0] next_temperature_ambient_result;
  logic [`TOFRS_DATA_W-1:0] next_ambient_cal_and_output_select;
  logic [4:0] next_frame_ctr;
  logic next_data_ready;
  logic [`TOFRS_DATA_W-1:0] next_reg_rdata;
  logic next_general_output_a;
  logic next_general_output_b;
  logic next_general_output_c;
  logic [9:0] ambient_cal_point;
  logic [10:0] ambient_diff;
  logic ambient_saturated;
  logic frame_valid;
  logic [3:0] out0_selector;
  logic [3:0] out1_selector;
  logic [3:0] out2_selector;

  assign ambient_cal_point =
    ambient_cal_and_output_select[`TOFRS_CTL_CAL_HI:`TOFRS_CTL_CAL_LO];
  assign out2_selector =
    ambient_cal_and_output_select[`TOFRS_CTL_SEL2_HI:`TOFRS_CTL_SEL2_LO];
  assign out1_selector =
    ambient_cal_and_output_select[`TOFRS_CTL_SEL1_HI:`TOFRS_CTL_SEL1_LO];
  assign out0_selector =
    ambient_cal_and_output_select[`TOFRS_CTL_SEL0_HI:`TOFRS_CTL_SEL0_LO];

  // Routes one internal signal to a general output; unlisted codes give low.
  function automatic logic route_out(input logic [3:0] sel, input logic rdy,
                                     input logic lsb);
    logic res;
    res = 1'b0;
    case (sel)
      TOFRS_SEL_FRAME_SYNC: res = i_frame_sync;
      TOFRS_SEL_SUBFRAME_SYNC: res = i_subframe_sync;
      TOFRS_SEL_SEQ_IRQ: res = i_seq_interrupt;
      TOFRS_SEL_COMP_STATUS: res = i_comp_status;
      TOFRS_SEL_DATA_READY: res = rdy;
      TOFRS_SEL_CTR_LSB: res = lsb;
      default: res = 1'b0;
    endcase
    return res;
  endfunction : route_out

  // Frame latch: every result field is captured on the same edge.
  always_comb begin
    ambient_diff = {1'b0, i_ambient_level} - {1'b0, ambient_cal_point};
    ambient_saturated = !ambient_diff[10] && (ambient_diff[9:0] > i_ambient_limit);
    frame_valid = !(i_internal_crosstalk_cal || i_optical_crosstalk_cal);
    next_frame_ctr = frame_ctr;
    next_phase_result = phase_result;
    next_amplitude_result = amplitude_result;
    next_temperature_ambient_result = temperature_ambient_result;
    if (i_frame_done) begin
      next_frame_ctr = frame_ctr + 5'h01;
      next_phase_result = {next_frame_ctr[0], ambient_saturated,
                           i_modulation_choice, frame_valid,
                           i_emitter, i_drive_level_used,
                           i_phase_wrap, i_phase};
      next_amplitude_result = {i_range_bin, i_second_freq_wrap,
                               i_signal_saturated, next_frame_ctr[2:1],
                               i_echo_amplitude};
      next_temperature_ambient_result = {i_die_temperature,
                                         i_ambient_level,
                                         next_frame_ctr[4:3]};
    end
  end

  // Host access: control register writes, read-back and the data-ready flag.
  always_comb begin
    next_ambient_cal_and_output_select = ambient_cal_and_output_select;
    if (i_reg_wr && (i_reg_addr == `TOFRS_CTL_ADDR)) begin
      next_ambient_cal_and_output_select =
        {i_reg_wdata[`TOFRS_CTL_CAL_HI:`TOFRS_CTL_SEL2_LO], 2'h0,
         i_reg_wdata[`TOFRS_CTL_SEL1_HI:`TOFRS_CTL_SEL0_LO]};
    end
    next_data_ready = data_ready;
    if (i_reg_rd && (i_reg_addr == `TOFRS_PHASE_ADDR)) begin
      next_data_ready = 1'b0;
    end
    if (i_frame_done) begin
      next_data_ready = 1'b1;
    end
    next_reg_rdata = o_reg_rdata;
    if (i_reg_rd) begin
      case (i_reg_addr)
        `TOFRS_PHASE_ADDR: next_reg_rdata = phase_result;
        `TOFRS_AMP_ADDR: next_reg_rdata = amplitude_result;
        `TOFRS_TEMP_ADDR: next_reg_rdata = temperature_ambient_result;
        `TOFRS_CTL_ADDR: next_reg_rdata = ambient_cal_and_output_select;
        default: next_reg_rdata = 24'h000000;
      endcase
    end
    next_general_output_a = route_out(out0_selector, data_ready, frame_ctr[0]);
    next_general_output_b = route_out(out1_selector, data_ready, frame_ctr[0]);
    next_general_output_c = route_out(out2_selector, data_ready, frame_ctr[0]);
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      phase_result <= `TOFRS_PHASE_RST;
      amplitude_result <= `TOFRS_AMP_RST;
      temperature_ambient_result <= `TOFRS_TEMP_RST;
      ambient_cal_and_output_select <= `TOFRS_CTL_RST;
      frame_ctr <= `TOFRS_CTR_RST;
      data_ready <= 1'b0;
      o_reg_rdata <= 24'h000000;
      o_general_output_a <= 1'b0;
      o_general_output_b <= 1'b0;
      o_general_output_c <= 1'b0;
    end else begin
      phase_result <= next_phase_result;
      amplitude_result <= next_amplitude_result;
      temperature_ambient_result <= next_temperature_ambient_result;
      ambient_cal_and_output_select <= next_ambient_cal_and_output_select;
      frame_ctr <= next_frame_ctr;
      data_ready <= next_data_ready;
      o_reg_rdata <= next_reg_rdata;
      o_general_output_a <= next_general_output_a;
      o_general_output_b <= next_general_output_b;
      o_general_output_c <= next_general_output_c;
    end
  end

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_b);

  // A frame completes and its fields are visible on the next edge.
  sequence s_frame_end;
    i_frame_done;
  endsequence

  sequence s_two_frames;
    i_frame_done ##1 i_frame_done;
  endsequence

  a_frame_ctr_split: assert property (
    s_frame_end |=> ({temperature_ambient_result[1:0], amplitude_result[17:16],
                      phase_result[`TOFRS_PH_CTR0_POS]} == $past(frame_ctr) + 5'h01))
    else $error("Frame counter fields do not hold the new count.");

  a_frame_ctr_pair: assert property (
    s_two_frames |=> (phase_result[`TOFRS_PH_CTR0_POS] != $past(phase_result[`TOFRS_PH_CTR0_POS])))
    else $error("Frame counter low bit did not toggle between frames.");

  a_ambient_sat_flag: assert property (
    s_frame_end |=> (phase_result[`TOFRS_PH_AMBSAT_POS] == $past(ambient_saturated)))
    else $error("Ambient saturation bit does not match the comparison.");

  a_ambient_sat_cmp: assert property (
    (i_ambient_level <= ambient_cal_point) |-> !ambient_saturated)
    else $error("Ambient saturation raised without level above cal point.");

  a_frame_valid_bit: assert property (
    s_frame_end and (i_internal_crosstalk_cal || i_optical_crosstalk_cal)
    |=> !phase_result[`TOFRS_PH_VALID_POS])
    else $error("Calibration frame reported as valid.");

  a_phase_fields: assert property (
    s_frame_end |=> (phase_result[21:16] == {$past(i_modulation_choice), $past(frame_valid),
                     $past(i_emitter), $past(i_drive_level_used), $past(i_phase_wrap)}))
    else $error("Phase status fields differ from the frame inputs.");

  a_amp_fields: assert property (
    s_frame_end |=> (amplitude_result[23:18] == {$past(i_range_bin),
                     $past(i_second_freq_wrap), $past(i_signal_saturated)}))
    else $error("Amplitude status fields differ from the frame inputs.");

  a_result_hold: assert property (
    !i_frame_done ##0 i_reg_wr |=> $stable(phase_result) && $stable(amplitude_result)
                                   && $stable(temperature_ambient_result))
    else $error("Result register changed without a frame end.");

  a_ctl_zero_bits: assert property (
    ambient_cal_and_output_select[`TOFRS_CTL_ZERO_HI:`TOFRS_CTL_ZERO_LO] == 2'h0)
    else $error("Reserved control bits are not zero.");

  a_ctl_write: assert property (
    i_reg_wr && (i_reg_addr == `TOFRS_CTL_ADDR)
    |=> ambient_cal_point == $past(i_reg_wdata[`TOFRS_CTL_CAL_HI:`TOFRS_CTL_CAL_LO]))
    else $error("Ambient calibration point not written.");

  a_read_back: assert property (
    i_reg_rd && (i_reg_addr == `TOFRS_AMP_ADDR) |=> o_reg_rdata == $past(amplitude_result))
    else $error("Amplitude read returned wrong data.");

  a_out_a_route: assert property (
    (out0_selector == TOFRS_SEL_DATA_READY) |=> o_general_output_a == $past(data_ready))
    else $error("First output does not follow data ready.");

  a_out_b_invalid: assert property (
    (out1_selector == 4'h2) |=> !o_general_output_b)
    else $error("Second output driven by an invalid selector code.");

endmodule : tofrs_top

// ---- tb/tofrs_host.sv ----
// Host controller model that drives the register port of the result register group.
`timescale 1ns/1ns
`include "tofrs_regs.svh"
module tofrs_host (
  input wire logic i_ref_clk,
  input wire logic [`TOFRS_DATA_W-1:0] i_rdata,
  output logic [`TOFRS_ADDR_W-1:0] o_addr,
  output logic o_wr,
  output logic o_rd,
  output logic [`TOFRS_DATA_W-1:0] o_wdata
);
  initial begin
    o_addr = 8'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_wdata = 24'h000000;
  end
  // Released address and data lines show the inverse of the requested address and data, not of the masked data driven.
  task automatic write_reg(input logic [7:0] a, input logic [23:0] d);
    o_addr <= a;
    o_wdata <= d & 24'hFFFCFF;
    o_wr <= 1'b1;
    @(posedge i_ref_clk);
    o_wr <= 1'b0;
    o_addr <= ~a;
    o_wdata <= ~d;
    @(posedge i_ref_clk);
  endtask : write_reg
  task automatic read_reg(input logic [7:0] a, output logic [23:0] d);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_ref_clk);
    o_rd <= 1'b0;
    o_addr <= ~a;
    @(posedge i_ref_clk);
    d = i_rdata;
  endtask : read_reg
endmodule : tofrs_host

// ---- tb/tb.sv ----
// Self-checking testbench of the result register group.
`timescale 1ns/1ns
`include "tofrs_regs.svh"
module tb;
  logic clk = 1'b0, rst_b = 1'b0, fdone = 1'b0, pwrap = 1'b0, modc = 1'b0, icx = 1'b0;
  logic ocx = 1'b0, drv = 1'b0, f2w = 1'b0, ssat = 1'b0, sfs = 1'b0, seq = 1'b0;
  logic fsync = 1'b0, cmp = 1'b0;
  logic [15:0] ph = 16'h0000, amp = 16'h0000;
  logic [11:0] die = 12'h000;
  logic [9:0] amb = 10'h000, lim = 10'h000;
  logic [3:0] bin = 4'h0;
  logic [1:0] emit = 2'h0;
  logic ga, gb, gc, wr, rd;
  logic [7:0] addr;
  logic [23:0] wdata, rdata;
  int err_count = 0, cmp_count = 0;
  always #4 clk = ~clk;
  tofrs_host i_tofrs_host (.i_ref_clk(clk), .i_rdata(rdata), .o_addr(addr), .o_wr(wr),
    .o_rd(rd), .o_wdata(wdata));
  tofrs_top i_tofrs_top (.i_ref_clk(clk), .i_rst_b(rst_b), .i_reg_addr(addr), .i_reg_wr(wr),
    .i_reg_rd(rd), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_frame_done(fdone),
    .i_phase(ph), .i_phase_wrap(pwrap), .i_modulation_choice(modc),
    .i_internal_crosstalk_cal(icx), .i_optical_crosstalk_cal(ocx), .i_emitter(emit),
    .i_drive_level_used(drv), .i_range_bin(bin), .i_second_freq_wrap(f2w),
    .i_signal_saturated(ssat), .i_echo_amplitude(amp), .i_die_temperature(die),
    .i_ambient_level(amb), .i_ambient_limit(lim), .i_frame_sync(fsync),
    .i_subframe_sync(sfs), .i_seq_interrupt(seq), .i_comp_status(cmp),
    .o_general_output_a(ga), .o_general_output_b(gb), .o_general_output_c(gc));
  task automatic check(input string name, input logic [23:0] exp, input logic [23:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task automatic rd_chk(input logic [7:0] a, input logic [23:0] exp);
    logic [23:0] d;
    i_tofrs_host.read_reg(a, d);
    check($sformatf("reg_%h", a), exp, d);
  endtask : rd_chk
  task automatic outs_chk(input logic [2:0] exp);
    repeat (2) @(posedge clk);
    #1;
    check("general_outputs", {21'h0, exp}, {21'h0, gc, gb, ga});
    @(posedge clk);
  endtask : outs_chk
  task automatic pulse_frame();
    fdone <= 1'b1;
    @(posedge clk);
    fdone <= 1'b0;
    @(posedge clk);
  endtask : pulse_frame
  task automatic t_reset();
    rd_chk(`TOFRS_PHASE_ADDR, `TOFRS_PHASE_RST);
    rd_chk(`TOFRS_AMP_ADDR, `TOFRS_AMP_RST);
    rd_chk(`TOFRS_TEMP_ADDR, `TOFRS_TEMP_RST);
    rd_chk(`TOFRS_CTL_ADDR, 24'h0FC009);
    rd_chk(8'h0C, 24'h000000);
  endtask : t_reset
  task automatic t_frame1();
    ph <= 16'hA5C3;
    pwrap <= 1'b1;
    modc <= 1'b1;
    emit <= 2'h2;
    drv <= 1'b1;
    bin <= 4'hC;
    f2w <= 1'b1;
    amp <= 16'h1234;
    die <= 12'hABC;
    amb <= 10'h100;
    lim <= 10'h050;
    pulse_frame();
    #1;
    check("data_ready_out", 24'h000001, {23'h0, ga});
    @(posedge clk);
    rd_chk(`TOFRS_PHASE_ADDR, 24'hFBA5C3);
    rd_chk(`TOFRS_AMP_ADDR, 24'hC81234);
    rd_chk(`TOFRS_TEMP_ADDR, 24'hABC400);
    check("data_ready_cleared", 24'h000000, {23'h0, ga});
  endtask : t_frame1
  task automatic t_write();
    i_tofrs_host.write_reg(`TOFRS_PHASE_ADDR, 24'hFFFFFF);
    i_tofrs_host.write_reg(`TOFRS_AMP_ADDR, 24'h000000);
    rd_chk(`TOFRS_PHASE_ADDR, 24'hFBA5C3);
    rd_chk(`TOFRS_AMP_ADDR, 24'hC81234);
    i_tofrs_host.write_reg(`TOFRS_CTL_ADDR, 24'h006B41);
    rd_chk(`TOFRS_CTL_ADDR, 24'h006841);
    sfs <= 1'b1;
    seq <= 1'b1;
    outs_chk(3'b111);
    sfs <= 1'b0;
    seq <= 1'b0;
    outs_chk(3'b100);
    i_tofrs_host.write_reg(`TOFRS_CTL_ADDR, 24'h004043);
    sfs <= 1'b1;
    seq <= 1'b1;
    fsync <= 1'b1;
    outs_chk(3'b110);
    i_tofrs_host.write_reg(`TOFRS_CTL_ADDR, 24'h006020);
    cmp <= 1'b1;
    outs_chk(3'b101);
    rd_chk(`TOFRS_CTL_ADDR, 24'h006020);
  endtask : t_write
  task automatic t_frame2();
    {pwrap, modc, emit, drv, bin, f2w, amp, die} <= '0;
    icx <= 1'b1;
    ssat <= 1'b1;
    ph <= 16'h0001;
    amb <= 10'h051;
    pulse_frame();
    rd_chk(`TOFRS_PHASE_ADDR, 24'h000001);
    rd_chk(`TOFRS_AMP_ADDR, 24'h050000);
    rd_chk(`TOFRS_TEMP_ADDR, 24'h000144);
    icx <= 1'b0;
    ocx <= 1'b1;
    pulse_frame();
    rd_chk(`TOFRS_PHASE_ADDR, 24'h800001);
    fdone <= 1'b1;
    repeat (6) @(posedge clk);
    fdone <= 1'b0;
    @(posedge clk);
    rd_chk(`TOFRS_PHASE_ADDR, 24'h800001);
    rd_chk(`TOFRS_AMP_ADDR, 24'h040000);
    rd_chk(`TOFRS_TEMP_ADDR, 24'h000145);
  endtask : t_frame2
  task automatic t_rerun();
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_reset();
    pulse_frame();
    rd_chk(`TOFRS_PHASE_ADDR, 24'h800001);
    rd_chk(`TOFRS_TEMP_ADDR, 24'h000144);
  endtask : t_rerun
  task automatic print_verdict();
    if (err_count == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict
  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_reset();
    t_frame1();
    t_write();
    t_frame2();
    t_rerun();
    print_verdict();
  end
  initial begin
    repeat (2000) @(posedge clk);
    err_count++;
    print_verdict();
  end
endmodule : tb
